// ---- backlight_ldo_pkg.sv ----
// Package with register map, field layout, timing and decode types for the light control bank
package backlight_ldo_pkg;

	// Register addresses on the latched write port
	localparam logic [4:0] ADDR_BACKLIGHT_CURRENT = 5'h00;
	localparam logic [4:0] ADDR_SINK_ENABLE       = 5'h01;
	localparam logic [4:0] ADDR_REGULATOR_ONE     = 5'h02;
	localparam logic [4:0] ADDR_REGULATOR_TWO     = 5'h03;
	localparam logic [4:0] ADDR_DIMMING           = 5'h04;

	// Register width and reset value
	localparam int         REG_WIDTH  = 6;
	localparam logic [5:0] REG_RESET  = 6'h00;

	// Field positions
	localparam int CODE_LSB      = 0;
	localparam int CODE_MSB      = 4;
	localparam int SINK_LSB      = 1;
	localparam int SINK_MSB      = 4;
	localparam int REG_ONE_MSB   = 3;
	localparam int REG_TWO_MSB   = 2;
	localparam int FADE_EN_BIT   = 0;
	localparam int RATE_LSB      = 1;
	localparam int RATE_MSB      = 2;

	// Current code landmarks
	localparam logic [4:0] CODE_OFF        = 5'h00;
	localparam logic [4:0] CODE_FIRST_REAL = 5'h04;

	// Step intervals per rate code, in milliseconds
	localparam int STEP_MS_RATE0 = 32;
	localparam int STEP_MS_RATE1 = 24;
	localparam int STEP_MS_RATE2 = 16;
	localparam int STEP_MS_RATE3 = 8;

	// Clock rate and timebase derivation
	localparam int CLK_HZ          = 20000000;
	localparam int MS_PER_S        = 1000;
	localparam int CYCLES_PER_MS   = CLK_HZ / MS_PER_S;

	// Fade engine states
	typedef enum logic [0:0] {
		FADE_IDLE = 1'b0,
		FADE_RAMP = 1'b1
	} fade_state_t;

	// One latched write from the single-wire front end
	typedef struct packed {
		logic       strobe;
		logic [4:0] addr;
		logic [5:0] data;
	} reg_write_t;

	// Analog-facing control word
	typedef struct packed {
		logic [4:0] currentCode;
		logic [3:0] sinkOn;
		logic [3:0] regulatorOneCode;
		logic [2:0] regulatorTwoCode;
	} analog_ctrl_t;

endpackage : backlight_ldo_pkg

// ---- backlight_ldo_register_fade.sv ----
// Write-only register bank with backlight fade engine and analog decode outputs
`timescale 1ns/1ps

// Contract
// - Sink driven only when its enable set
// - Enabled sinks share current decoded from code
// - Code zero gives zero; codes 1-3 reserved
// - Four enable bits, positions one to four
// - Regulator one code decodes off or voltage
// - Regulator two code decodes off or voltage
// - Rate field selects 32/24/16/8 ms steps
// - Fade steps equal code difference
// - Step applied code toward target each interval
// - No current write accepted during fade
// - Clearing fade enable jumps to target
// - Fade off applies written code immediately
// - Rate writes accepted anytime, used from next cycle, mid-ramp too
// - Bit zero of dimming register enables fade
// - Five registers write-only, reset to zero
module backlight_ldo_register_fade #(
	parameter int STEP_CYCLES_PER_MS = backlight_ldo_pkg::CYCLES_PER_MS
) (
	input  wire logic                             sys_clk,
	input  wire logic                             rstn,
	input  wire logic                             clkEnable,
	input  wire backlight_ldo_pkg::reg_write_t    regWrite,
	output logic [4:0]                            appliedCode,
	output logic [3:0]                            sinkActive,
	output logic [5:0]                            sinkCurrentHalfMa,
	output logic                                  regulatorOneOn,
	output logic [5:0]                            regulatorOneDeciVolt,
	output logic                                  regulatorTwoOn,
	output logic [4:0]                            regulatorTwoDeciVolt,
	output logic                                  fadeBusy,
	output backlight_ldo_pkg::analog_ctrl_t       analogCtrl
);

	// Elaboration check on the millisecond divider
	if (STEP_CYCLES_PER_MS < 1 || STEP_CYCLES_PER_MS > 65535) begin : g_bad_divider
		$error("STEP_CYCLES_PER_MS out of range");
	end

	// Stored register contents, fade engine state and millisecond timebase
	logic [4:0]                        targetCode;       // Last accepted current code
	logic [3:0]                        sinkEnableBits;   // Per-sink enables
	logic [3:0]                        regulatorOneCode; // Regulator one code
	logic [2:0]                        regulatorTwoCode; // Regulator two code
	logic [1:0]                        fadeRate;         // Step rate select
	logic                              fadeEnable;       // Fade feature on
	backlight_ldo_pkg::fade_state_t    fadeState;        // Fade engine state
	logic [4:0]                        rampCode;         // Code being stepped
	logic [15:0]                       msCount;          // Cycles within a millisecond
	logic [5:0]                        stepMs;           // Milliseconds since last step

	// Milliseconds per step for a rate code
	function automatic logic [5:0] rate_to_ms(input logic [1:0] rate);
		case (rate)
			2'b00:   rate_to_ms = 6'(backlight_ldo_pkg::STEP_MS_RATE0);
			2'b01:   rate_to_ms = 6'(backlight_ldo_pkg::STEP_MS_RATE1);
			2'b10:   rate_to_ms = 6'(backlight_ldo_pkg::STEP_MS_RATE2);
			default: rate_to_ms = 6'(backlight_ldo_pkg::STEP_MS_RATE3);
		endcase
	endfunction : rate_to_ms

	// Backlight current in half-milliamp units
	function automatic logic [5:0] code_to_half_ma(input logic [4:0] code);
		logic [5:0] c;
		c = {1'b0, code};
		if (code < backlight_ldo_pkg::CODE_FIRST_REAL) begin
			code_to_half_ma = 6'h00;
		end else if (code <= 5'h0D) begin
			code_to_half_ma = c - 6'h03;
		end else if (code <= 5'h0F) begin
			code_to_half_ma = (c << 1) - 6'h10;
		end else if (code <= 5'h1D) begin
			code_to_half_ma = (c << 1) - 6'h10;
		end else if (code == 5'h1E) begin
			code_to_half_ma = 6'h2E;
		end else begin
			code_to_half_ma = 6'h32;
		end
	endfunction : code_to_half_ma

	// Write decode
	wire writeCurrent = clkEnable && regWrite.strobe
		&& regWrite.addr == backlight_ldo_pkg::ADDR_BACKLIGHT_CURRENT;
	wire writeSink    = clkEnable && regWrite.strobe
		&& regWrite.addr == backlight_ldo_pkg::ADDR_SINK_ENABLE;
	wire writeRegOne  = clkEnable && regWrite.strobe
		&& regWrite.addr == backlight_ldo_pkg::ADDR_REGULATOR_ONE;
	wire writeRegTwo  = clkEnable && regWrite.strobe
		&& regWrite.addr == backlight_ldo_pkg::ADDR_REGULATOR_TWO;
	wire writeDimming = clkEnable && regWrite.strobe
		&& regWrite.addr == backlight_ldo_pkg::ADDR_DIMMING;

	// Field extraction
	wire [4:0] newCode     = regWrite.data[backlight_ldo_pkg::CODE_MSB:backlight_ldo_pkg::CODE_LSB];
	wire       newFadeEn   = regWrite.data[backlight_ldo_pkg::FADE_EN_BIT];
	wire [1:0] newRate     = regWrite.data[backlight_ldo_pkg::RATE_MSB:backlight_ldo_pkg::RATE_LSB];

	// Fade status and timebase
	wire ramping       = fadeState == backlight_ldo_pkg::FADE_RAMP;
	wire acceptCurrent = writeCurrent && !ramping;
	wire msTick        = msCount == 16'(STEP_CYCLES_PER_MS - 1);
	wire stepDue       = ramping && msTick && (stepMs + 6'h01) >= rate_to_ms(fadeRate);
	wire cancelFade    = ramping && writeDimming && !newFadeEn;
	wire [4:0] stepped = (rampCode < targetCode) ? rampCode + 5'h01 : rampCode - 5'h01;

	// Next state of fade engine
	backlight_ldo_pkg::fade_state_t next_fadeState;
	logic [4:0]                     next_rampCode;
	always_comb begin
		next_fadeState = fadeState;
		next_rampCode  = rampCode;
		case (fadeState)
			backlight_ldo_pkg::FADE_IDLE: begin
				if (acceptCurrent && fadeEnable && newCode != rampCode) begin
					next_fadeState = backlight_ldo_pkg::FADE_RAMP;
				end else if (acceptCurrent) begin
					next_rampCode = newCode;
				end
			end
			backlight_ldo_pkg::FADE_RAMP: begin
				if (cancelFade) begin
					next_rampCode  = targetCode;
					next_fadeState = backlight_ldo_pkg::FADE_IDLE;
				end else if (stepDue) begin
					next_rampCode = stepped;
					if (stepped == targetCode) begin
						next_fadeState = backlight_ldo_pkg::FADE_IDLE;
					end
				end
			end
			default: begin
				next_fadeState = backlight_ldo_pkg::FADE_IDLE;
				next_rampCode  = targetCode;
			end
		endcase
	end

	// Register bank, all cleared at reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			targetCode       <= 5'h00;
			sinkEnableBits   <= 4'h0;
			regulatorOneCode <= 4'h0;
			regulatorTwoCode <= 3'h0;
			fadeRate         <= 2'h0;
			fadeEnable       <= 1'b0;
		end else begin
			if (acceptCurrent) begin
				targetCode <= newCode;
			end
			if (writeSink) begin
				sinkEnableBits <= regWrite.data[backlight_ldo_pkg::SINK_MSB:backlight_ldo_pkg::SINK_LSB];
			end
			if (writeRegOne) begin
				regulatorOneCode <= regWrite.data[backlight_ldo_pkg::REG_ONE_MSB:0];
			end
			if (writeRegTwo) begin
				regulatorTwoCode <= regWrite.data[backlight_ldo_pkg::REG_TWO_MSB:0];
			end
			if (writeDimming) begin
				fadeRate   <= newRate;
				fadeEnable <= newFadeEn;
			end
		end
	end

	// Fade engine state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fadeState <= backlight_ldo_pkg::FADE_IDLE;
			rampCode  <= 5'h00;
		end else if (clkEnable) begin
			fadeState <= next_fadeState;
			rampCode  <= next_rampCode;
		end
	end

	// Millisecond timebase, restarted at fade start and each step
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			msCount <= 16'h0000;
			stepMs  <= 6'h00;
		end else if (clkEnable) begin
			if (!ramping || stepDue) begin
				msCount <= 16'h0000;
				stepMs  <= 6'h00;
			end else if (msTick) begin
				msCount <= 16'h0000;
				stepMs  <= stepMs + 6'h01;
			end else begin
				msCount <= msCount + 16'h0001;
			end
		end
	end

	// Decoded analog controls
	wire [5:0] nextHalfMa   = code_to_half_ma(next_rampCode);
	wire [3:0] nextSinks    = (next_rampCode == backlight_ldo_pkg::CODE_OFF) ? 4'h0
		: (writeSink ? regWrite.data[4:1] : sinkEnableBits);
	wire [3:0] nextRegOne   = writeRegOne ? regWrite.data[3:0] : regulatorOneCode;
	wire [2:0] nextRegTwo   = writeRegTwo ? regWrite.data[2:0] : regulatorTwoCode;
	// 1..10 give 34-code, 11 gives 22, 12..15 give 30-code
	wire [5:0] nextOneVolt  = (nextRegOne == 4'h0) ? 6'h00
		: (nextRegOne <= 4'hA) ? 6'(6'h22 - {2'b00, nextRegOne})
		: (nextRegOne == 4'hB) ? 6'h16
		: 6'(6'h1E - {2'b00, nextRegOne});
	wire [4:0] nextTwoVolt  = (nextRegTwo == 3'h0) ? 5'h00
		: 5'(5'h13 - {2'b00, nextRegTwo});

	// Output flops, frozen with clock enable
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			appliedCode          <= 5'h00;
			sinkActive           <= 4'h0;
			sinkCurrentHalfMa    <= 6'h00;
			regulatorOneOn       <= 1'b0;
			regulatorOneDeciVolt <= 6'h00;
			regulatorTwoOn       <= 1'b0;
			regulatorTwoDeciVolt <= 5'h00;
			fadeBusy             <= 1'b0;
			analogCtrl           <= '0;
		end else if (clkEnable) begin
			appliedCode          <= next_rampCode;
			sinkActive           <= nextSinks;
			sinkCurrentHalfMa    <= nextHalfMa;
			regulatorOneOn       <= nextRegOne != 4'h0;
			regulatorOneDeciVolt <= nextOneVolt;
			regulatorTwoOn       <= nextRegTwo != 3'h0;
			regulatorTwoDeciVolt <= nextTwoVolt;
			fadeBusy             <= next_fadeState == backlight_ldo_pkg::FADE_RAMP;
			analogCtrl           <= '{next_rampCode, nextSinks, nextRegOne, nextRegTwo};
		end
	end

endmodule : backlight_ldo_register_fade

// ---- backlight_ldo_register_fade_properties.sv ----
// Port-level decode and timing checks for the light control bank
`timescale 1ns/1ps
module backlight_ldo_register_fade_properties #(
	parameter int STEP_CYCLES_PER_MS = 2
) (
	input wire logic                           sys_clk,
	input wire logic                           rstn,
	input wire logic                           clkEnable,
	input wire backlight_ldo_pkg::reg_write_t  regWrite,
	input wire logic [4:0]                     appliedCode,
	input wire logic [3:0]                     sinkActive,
	input wire logic [5:0]                     sinkCurrentHalfMa,
	input wire logic                           regulatorOneOn,
	input wire logic [5:0]                     regulatorOneDeciVolt,
	input wire logic                           regulatorTwoOn,
	input wire logic [4:0]                     regulatorTwoDeciVolt,
	input wire logic                           fadeBusy,
	input wire backlight_ldo_pkg::analog_ctrl_t analogCtrl
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Enabled write strobe to the current code register, taken or not
	wire logic codeWr = clkEnable && regWrite.strobe && regWrite.addr == 5'h00;
	wire logic [3:0] oneCode = analogCtrl.regulatorOneCode;
	wire logic [2:0] twoCode = analogCtrl.regulatorTwoCode;
	// Half-milliamp current per code
	function automatic logic [5:0] halfMa(input logic [4:0] c);
		if (c < 5'h04) return 6'h00;
		if (c < 5'h0E) return {1'b0, c} - 6'h03;
		if (c < 5'h1E) return {c, 1'b0} - 6'h10;
		return (c == 5'h1E) ? 6'h2E : 6'h32;
	endfunction : halfMa
	// Regulator one tenths of a volt per code
	function automatic logic [5:0] oneDv(input logic [3:0] c);
		if (c == 4'h0) return 6'h00;
		if (c < 4'hB) return 6'h22 - {2'h0, c};
		return (c == 4'hB) ? 6'h16 : 6'h1E - {2'h0, c};
	endfunction : oneDv
	// Fade cancel write and ramp step
	sequence cancelWr;
		clkEnable && regWrite.strobe && regWrite.addr == 5'h04 && !regWrite.data[0];
	endsequence
	sequence rampStep;
		fadeBusy && $past(fadeBusy) && $changed(appliedCode);
	endsequence
	a_sink_zero_code: assert property (appliedCode == 5'h00 |-> sinkActive == 4'h0)
		else $error("sink active with zero code");
	a_reserved_zero: assert property (appliedCode < 5'h04 |-> sinkCurrentHalfMa == 6'h00)
		else $error("current for reserved code");
	a_current_decode: assert property (sinkCurrentHalfMa == halfMa(appliedCode))
		else $error("sink current decode wrong");
	a_reg_one_volt: assert property (regulatorOneDeciVolt == oneDv(oneCode) && regulatorOneOn == (oneCode != 4'h0))
		else $error("regulator one decode wrong");
	a_reg_two_volt: assert property (regulatorTwoDeciVolt == (regulatorTwoOn ? 5'h13 - {2'h0, twoCode} : 5'h00) && regulatorTwoOn == (twoCode != 3'h0))
		else $error("regulator two decode wrong");
	a_step_by_one: assert property (rampStep |-> appliedCode - $past(appliedCode) == 5'h01 || $past(appliedCode) - appliedCode == 5'h01)
		else $error("ramp step not one");
	a_step_gap: assert property (rampStep |=> ($stable(appliedCode) || !fadeBusy)[*8])
		else $error("ramp steps too close");
	a_idle_write: assert property (!fadeBusy && codeWr |=> appliedCode == $past(regWrite.data[4:0]) || fadeBusy)
		else $error("direct write not applied");
	a_ramp_start: assert property (!fadeBusy && codeWr |=> !fadeBusy || $stable(appliedCode))
		else $error("ramp start jumped");
	a_cancel_jump: assert property (fadeBusy ##0 cancelWr |=> !fadeBusy)
		else $error("cancel left ramp running");
	a_analog_mirror: assert property (analogCtrl.currentCode == appliedCode && analogCtrl.sinkOn == sinkActive)
		else $error("analog word mismatch");
endmodule : backlight_ldo_register_fade_properties
bind backlight_ldo_register_fade backlight_ldo_register_fade_properties #(
	.STEP_CYCLES_PER_MS(STEP_CYCLES_PER_MS)) props (.sys_clk(sys_clk), .rstn(rstn),
	.clkEnable(clkEnable), .regWrite(regWrite), .appliedCode(appliedCode),
	.sinkActive(sinkActive), .sinkCurrentHalfMa(sinkCurrentHalfMa),
	.regulatorOneOn(regulatorOneOn), .regulatorOneDeciVolt(regulatorOneDeciVolt),
	.regulatorTwoOn(regulatorTwoOn), .regulatorTwoDeciVolt(regulatorTwoDeciVolt),
	.fadeBusy(fadeBusy), .analogCtrl(analogCtrl));

// ---- host_writer.sv ----
// Host model issuing latched register writes
`timescale 1ns/1ps
module host_writer (
	input  wire logic                    sys_clk,
	output backlight_ldo_pkg::reg_write_t regWrite
);
	// Field bits per register; unused bits forced to zero
	function automatic logic [5:0] fieldMask(input logic [4:0] a);
		case (a)
			5'h00: return 6'h1F;
			5'h01: return 6'h1E;
			5'h02: return 6'h0F;
			default: return 6'h07;
		endcase
	endfunction : fieldMask
	initial regWrite = '0;
	// One-cycle strobe; stale fields inverted once released
	task automatic put(input logic [4:0] a, input logic [5:0] d);
		@(negedge sys_clk);
		regWrite = '{strobe: 1'b1, addr: a, data: d & fieldMask(a)};
		@(negedge sys_clk);
		regWrite = '{strobe: 1'b0, addr: ~a, data: ~d};
	endtask : put
endmodule : host_writer

// ---- backlight_ldo_register_fade_tb.sv ----
// Self-checking bench for the light control bank
`timescale 1ns/1ps
module backlight_ldo_register_fade_tb;
	logic sys_clk, rstn, clkEnable, regulatorOneOn, regulatorTwoOn, fadeBusy;
	backlight_ldo_pkg::reg_write_t  regWrite;
	backlight_ldo_pkg::analog_ctrl_t analogCtrl;
	logic [4:0] appliedCode, regulatorTwoDeciVolt;
	logic [3:0] sinkActive;
	logic [5:0] sinkCurrentHalfMa, regulatorOneDeciVolt;
	int         mismatches, check_count, n;
	host_writer h (.sys_clk(sys_clk), .regWrite(regWrite));
	backlight_ldo_register_fade #(.STEP_CYCLES_PER_MS(2)) dut (.sys_clk(sys_clk), .rstn(rstn),
		.clkEnable(clkEnable), .regWrite(regWrite), .appliedCode(appliedCode),
		.sinkActive(sinkActive), .sinkCurrentHalfMa(sinkCurrentHalfMa),
		.regulatorOneOn(regulatorOneOn), .regulatorOneDeciVolt(regulatorOneDeciVolt),
		.regulatorTwoOn(regulatorTwoOn), .regulatorTwoDeciVolt(regulatorTwoDeciVolt),
		.fadeBusy(fadeBusy), .analogCtrl(analogCtrl));
	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Host holds off until the ramp ends; c counts cycles waited
	task automatic waitIdle(output int c);
		c = 0;
		while (fadeBusy === 1'b1 && c < 2000) begin
			@(negedge sys_clk);
			c++;
		end
	endtask : waitIdle
	// Verdict and end of run
	task test_done;
		if (mismatches == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	// 50 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Watchdog well past the expected run length
	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		test_done();
	end
	// Main sequence
	initial begin
		mismatches = 0;
		check_count = 0;
		rstn = 1'b0;
		clkEnable = 1'b1;
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk) rstn = 1'b1;
		chk(analogCtrl, 16'h0000);
		chk({regulatorOneDeciVolt, regulatorTwoDeciVolt, fadeBusy}, 16'h0000);
		for (n = 0; n < 32; n++) if (n == 0 || n > 3) begin
			h.put(5'h00, 6'(n));
			chk(appliedCode, 16'(n));
			chk(sinkActive, 16'h0000);
		end
		for (n = 0; n < 4; n++) begin
			h.put(5'h01, 6'h02 << n);
			chk(sinkActive, 4'h1 << n);
		end
		h.put(5'h01, 6'h1E);
		chk(sinkCurrentHalfMa, 16'h0032);
		h.put(5'h00, 6'h1E);
		chk(sinkCurrentHalfMa, 16'h002E);
		for (n = 0; n < 16; n++) begin
			h.put(5'h02, 6'(n));
			chk(regulatorOneDeciVolt, n == 0 ? 0 : n < 11 ? 34 - n : n == 11 ? 22 : 30 - n);
		end
		for (n = 0; n < 8; n++) begin
			h.put(5'h03, 6'(n));
			chk(regulatorTwoDeciVolt, n == 0 ? 0 : 19 - n);
		end
		h.put(5'h05, 6'h3F);
		chk(analogCtrl, {5'h1E, 4'hF, 4'hF, 3'h7});
		@(negedge sys_clk) clkEnable = 1'b0;
		h.put(5'h00, 6'h04);
		chk(appliedCode, 16'h001E);
		@(negedge sys_clk) clkEnable = 1'b1;
		h.put(5'h00, 6'h04);
		h.put(5'h04, 6'h07);
		h.put(5'h00, 6'h07);
		chk({fadeBusy, appliedCode}, {1'b1, 5'h04});
		h.put(5'h00, 6'h14);
		waitIdle(n);
		chk(appliedCode, 16'h0007);
		chk(n inside {[36:50]}, 16'h0001);
		h.put(5'h04, 6'h01);
		h.put(5'h00, 6'h0A);
		h.put(5'h04, 6'h07);
		waitIdle(n);
		chk(appliedCode, 16'h000A);
		chk(n inside {[36:50]}, 16'h0001);
		h.put(5'h00, 6'h06);
		waitIdle(n);
		chk(appliedCode, 16'h0006);
		chk(n inside {[58:66]}, 16'h0001);
		h.put(5'h00, 6'h1F);
		repeat (40) @(negedge sys_clk);
		chk(fadeBusy, 16'h0001);
		h.put(5'h04, 6'h06);
		chk({fadeBusy, appliedCode}, {1'b0, 5'h1F});
		h.put(5'h00, 6'h04);
		chk(appliedCode, 16'h0004);
		test_done();
	end
endmodule : backlight_ldo_register_fade_tb
